// ### inc/nbc_pkg.sv
// nbc_pkg: shared constants and carriers for the nand bus cycle host
package nbc_pkg;

  // ----------------------------------------
  // bus widths
  // ----------------------------------------
  localparam int DATA_W = 16;
  localparam int COL_W = 12;
  localparam int ROW_W = 17;

  // ----------------------------------------
  // address layout, byte-wide
  // ----------------------------------------
  localparam int X8_COL_HI_W = 4;
  localparam int X8_PLANE_BIT = 18;
  localparam int X8_ROW_LSB = 12;

  // ----------------------------------------
  // address layout, word-wide
  // ----------------------------------------
  localparam int X16_COL_HI_W = 3;
  localparam int X16_PLANE_BIT = 17;
  localparam int X16_ROW_LSB = 11;

  // ----------------------------------------
  // page geometry
  // ----------------------------------------
  localparam int PAGE_MAIN_BYTES = 2048;
  localparam int PAGE_SPARE_BYTES = 128;
  localparam int PAGE_MAIN_WORDS = 1024;
  localparam int PAGE_SPARE_WORDS = 64;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int PAGE_SEL_W = 6;
  localparam int ADDR_CYCLES = 5;

  // ----------------------------------------
  // strobe timing, 40 MHz clock
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int STROBE_LOW_NS = 25;
  localparam int STROBE_HIGH_NS = 25;
  localparam int OUTPUT_ACCESS_DELAY_NS = 25;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OUTPUT_ACCESS_DELAY_CYC = (OUTPUT_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 4;

  // ----------------------------------------
  // request kinds
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    NBC_OP_CMD,
    NBC_OP_ADDR,
    NBC_OP_DIN,
    NBC_OP_DOUT,
    NBC_OP_IDLE
  } nbc_op_t;

  typedef struct packed
  {
    nbc_op_t op;
    logic wide;
    logic [DATA_W-1:0] data;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
  } nbc_req_t;

  typedef struct packed
  {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic re_n;
    logic wp_n;
  } nbc_pins_t;

endpackage : nbc_pkg

// ### src/nbc_addr_fmt.sv
// nbc_addr_fmt: builds one address cycle word from column and row
`timescale 1ns/1ps
module nbc_addr_fmt
(
  // selection
  input wire logic wide,
  input wire logic [2:0] cycle_idx,
  // address
  input wire logic [nbc_pkg::COL_W-1:0] col,
  input wire logic [nbc_pkg::ROW_W-1:0] row,
  // result
  output logic [nbc_pkg::DATA_W-1:0] word
);

  // ----------------------------------------
  // cycle mux
  // ----------------------------------------
  // row is the row part only: row[0] is A12 (x8) or A11 (x16)
  always_comb
  begin
    word = 16'h0000;
    unique case (cycle_idx)
      3'h0: word[7:0] = col[7:0];
      3'h1:
      begin
        if (wide)
          word[2:0] = col[10:8];
        else
          word[3:0] = col[11:8];
      end
      3'h2: word[7:0] = row[7:0];
      3'h3: word[7:0] = row[15:8];
      3'h4: word[0] = row[16];
      default: word = 16'h0000;
    endcase
  end

endmodule : nbc_addr_fmt

// ### src/nbc_host.sv
// nbc_host: controller side of the multiplexed nand command/address/data bus
//
// How it works
// - ready/busy open-drain, high only when released
// - x8 column: cycle one low, cycle two nibble
// - x8 row: three cycles, fifth holds one bit
// - x16 column: cycle two holds three bits
// - x16 row: three cycles, fifth holds one bit
// - unused address bits and upper byte low
// - read: latches low, input strobe high
`timescale 1ns/1ps
module nbc_host
#(
  parameter int LOW_CYC = nbc_pkg::STROBE_LOW_CYC,
  parameter int HIGH_CYC = nbc_pkg::STROBE_HIGH_CYC,
  parameter int ACCESS_CYC = nbc_pkg::OUTPUT_ACCESS_DELAY_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // user request
  input wire logic req_valid,
  input wire nbc_pkg::nbc_req_t req,
  input wire logic wp_allow,
  output logic req_ready,
  // user answer
  output logic rsp_valid,
  output logic [nbc_pkg::DATA_W-1:0] rsp_data,
  output logic dev_ready,
  output logic [nbc_pkg::COL_W-1:0] col_ptr,
  // device pins
  output nbc_pkg::nbc_pins_t pins,
  input wire logic [nbc_pkg::DATA_W-1:0] io_in,
  output logic [nbc_pkg::DATA_W-1:0] io_out,
  output logic io_oe,
  input wire logic ready_busy_n
);

  typedef enum
  {
    ST_IDLE,
    ST_SETUP,
    ST_LOW,
    ST_HIGH
  } nbc_state_t;

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic rb_meta_ff;
  logic rb_sync_ff;
  logic [nbc_pkg::DATA_W-1:0] io_meta_ff;
  logic [nbc_pkg::DATA_W-1:0] io_sync_ff;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rb_meta_ff <= 1'b0;
      rb_sync_ff <= 1'b0;
    end
    else
    begin
      rb_meta_ff <= ready_busy_n;
      rb_sync_ff <= rb_meta_ff;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      io_meta_ff <= 16'h0000;
      io_sync_ff <= 16'h0000;
    end
    else
    begin
      io_meta_ff <= io_in;
      io_sync_ff <= io_meta_ff;
    end
  end

  // open-drain line, pull-up outside: high means released
  assign dev_ready = rb_sync_ff;

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  nbc_state_t state_ff;
  nbc_state_t nxt_state;
  nbc_pkg::nbc_req_t cur_ff;
  logic [2:0] acyc_ff;
  logic [nbc_pkg::TIMER_W-1:0] tmr_ff;
  logic tmr_done;
  logic blocked;
  logic last_acyc;
  logic [nbc_pkg::DATA_W-1:0] addr_word;

  assign tmr_done = (tmr_ff == 4'h0);
  assign last_acyc = (acyc_ff == 3'(nbc_pkg::ADDR_CYCLES - 1));
  // program data refused while protected; commands still pass, device rejects them
  assign blocked = (req.op == nbc_pkg::NBC_OP_DIN) && !wp_allow;
  assign req_ready = (state_ff == ST_IDLE) && !blocked;

  nbc_addr_fmt u_fmt
  (
    .wide(cur_ff.wide),
    .cycle_idx(acyc_ff),
    .col(cur_ff.col),
    .row(cur_ff.row),
    .word(addr_word)
  );

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: if (req_valid && req_ready && req.op != nbc_pkg::NBC_OP_IDLE) nxt_state = ST_SETUP;
      ST_SETUP: nxt_state = ST_LOW;
      ST_LOW: if (tmr_done) nxt_state = ST_HIGH;
      ST_HIGH:
      begin
        if (tmr_done)
        begin
          if (cur_ff.op == nbc_pkg::NBC_OP_ADDR && !last_acyc)
            nxt_state = ST_SETUP;
          else
            nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cur_ff <= '0;
    else if (state_ff == ST_IDLE && nxt_state == ST_SETUP)
      cur_ff <= req;
  end

  // five cycles always sent; device drops what it does not need
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      acyc_ff <= 3'h0;
    else if (state_ff == ST_IDLE)
      acyc_ff <= 3'h0;
    else if (state_ff == ST_HIGH && tmr_done)
      acyc_ff <= acyc_ff + 3'h1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      tmr_ff <= 4'h0;
    // read strobe stays low until the word has crossed both io_in sync stages
    else if (state_ff == ST_SETUP)
      tmr_ff <= (cur_ff.op == nbc_pkg::NBC_OP_DOUT) ? 4'(ACCESS_CYC + 1) : 4'(LOW_CYC - 1);
    else if (state_ff == ST_LOW && tmr_done)
      tmr_ff <= 4'(HIGH_CYC - 1);
    else if (!tmr_done)
      tmr_ff <= tmr_ff - 4'h1;
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  logic active;
  logic is_dout;
  nbc_pkg::nbc_op_t launch_op;

  assign active = (state_ff != ST_IDLE);
  assign is_dout = (cur_ff.op == nbc_pkg::NBC_OP_DOUT);
  // cur_ff still holds the previous op on the accept edge, so latches follow req there
  assign launch_op = (state_ff == ST_IDLE) ? req.op : cur_ff.op;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pins <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0};
    else
    begin
      pins.ce_n <= !(active || nxt_state != ST_IDLE);
      pins.cle <= (nxt_state != ST_IDLE) && (launch_op == nbc_pkg::NBC_OP_CMD);
      pins.ale <= (nxt_state != ST_IDLE) && (launch_op == nbc_pkg::NBC_OP_ADDR);
      pins.we_n <= !(nxt_state == ST_LOW && !is_dout);
      pins.re_n <= !(nxt_state == ST_LOW && is_dout);
      pins.wp_n <= wp_allow;
    end
  end

  // data loaded on the edge that ends setup, with the falling strobe, and held through the rising strobe edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      io_out <= 16'h0000;
      io_oe <= 1'b0;
    end
    else
    begin
      io_oe <= active && !is_dout;
      if (state_ff == ST_SETUP)
        io_out <= (cur_ff.op == nbc_pkg::NBC_OP_ADDR) ? addr_word
                  : (cur_ff.wide ? cur_ff.data : {8'h00, cur_ff.data[7:0]});
    end
  end

  // ----------------------------------------
  // read capture and column shadow
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (is_dout && state_ff == ST_LOW && tmr_done)
      begin
        rsp_valid <= 1'b1;
        rsp_data <= cur_ff.wide ? io_sync_ff : {8'h00, io_sync_ff[7:0]};
      end
    end
  end

  // shadow of the device column: loaded by address, bumped per data word
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      col_ptr <= 12'h000;
    else if (state_ff == ST_IDLE && nxt_state == ST_SETUP && req.op == nbc_pkg::NBC_OP_ADDR)
      col_ptr <= req.col;
    else if (state_ff == ST_HIGH && tmr_done && (is_dout || cur_ff.op == nbc_pkg::NBC_OP_DIN))
      col_ptr <= col_ptr + 12'h001;
  end

  // plane bit (A18 x8 / A17 x16) and page bits are row[6] and row[5:0] of the row field
  // so the caller places them; nothing here reorders them

endmodule : nbc_host

// ### test/nbc_host_props.sv
// nbc_host_props: port checks for the nand host
`timescale 1ns/1ps
module nbc_host_props
(
  // clock, reset
  input wire logic clk,
  input wire logic sys_rst,
  // user side
  input wire logic req_valid,
  input wire nbc_pkg::nbc_req_t req,
  input wire logic wp_allow,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic dev_ready,
  // device pins
  input wire nbc_pkg::nbc_pins_t pins,
  input wire logic [15:0] io_out,
  input wire logic io_oe,
  input wire logic ready_busy_n
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_rd;
    $fell(pins.re_n);
  endsequence
  sequence s_ans;
    ##[1:3] rsp_valid;
  endsequence
  // two sync flops, so three low cycles must show
  sequence s_busy;
    !ready_busy_n [*3];
  endsequence
  chk_ce_float: assert property (pins.ce_n |-> !io_oe) else $error("bus driven idle");
  chk_we_data: assert property ($rose(pins.we_n) |-> io_oe && $stable(io_out)) else $error("we data");
  chk_read_ans: assert property (s_rd |-> s_ans) else $error("no read answer");
  chk_addr_pins: assert property (pins.ale |-> !pins.cle && !pins.ce_n && pins.re_n) else $error("ale");
  chk_cmd_pins: assert property (pins.cle |-> !pins.ale && !pins.ce_n && pins.re_n) else $error("cle");
  chk_wp_refuse: assert property (req_valid && req.op == nbc_pkg::NBC_OP_DIN && !wp_allow |-> !req_ready)
    else $error("wp");
  chk_busy_seen: assert property (s_busy |-> !dev_ready) else $error("busy");
  chk_read_pins: assert property (!pins.re_n |-> pins.we_n && !pins.cle && !pins.ale && !pins.ce_n && !io_oe)
    else $error("read pins");
  chk_addr_upper: assert property (pins.ale && !pins.we_n |-> io_out[15:8] == 8'h00) else $error("upper");
endmodule : nbc_host_props

bind nbc_host nbc_host_props chk_u
(
  .clk(clk),
  .sys_rst(sys_rst),
  .req_valid(req_valid),
  .req(req),
  .wp_allow(wp_allow),
  .req_ready(req_ready),
  .rsp_valid(rsp_valid),
  .dev_ready(dev_ready),
  .pins(pins),
  .io_out(io_out),
  .io_oe(io_oe),
  .ready_busy_n(ready_busy_n)
);

// ### test/nbc_dev_model.sv
// nbc_dev_model: behavioural flash device facing the host
`timescale 1ns/1ps
module nbc_dev_model
#(
  parameter int BUSY_NS = 500
)
(
  // host pins
  input wire nbc_pkg::nbc_pins_t pins,
  input wire logic [15:0] io_bus,
  // device drive
  output logic [15:0] dev_q,
  output logic dev_oe,
  output logic rb_low
);
  logic [7:0] last_cmd;
  logic [15:0] addr_w [5];
  logic [15:0] mem [4096];
  logic [11:0] col;
  logic plane;
  logic [5:0] page;
  int acnt;
  initial
  begin
    acnt = 0;
    col = 12'h000;
    rb_low = 1'b0;
  end
  // released at once, so a late sample sees junk
  assign dev_oe = !pins.ce_n && !pins.re_n;
  always @(posedge pins.we_n)
    if (!pins.ce_n && pins.re_n)
    begin
      if (pins.cle)
      begin
        last_cmd = io_bus[7:0];
        if ((io_bus[7:0] == 8'h10 || io_bus[7:0] == 8'hD0) && pins.wp_n)
        begin
          rb_low = 1'b1;
          rb_low <= #(BUSY_NS) 1'b0;
        end
      end
      else if (pins.ale)
      begin
        addr_w[acnt] = io_bus;
        if (acnt == 1) col = {io_bus[3:0], addr_w[0][7:0]};
        if (acnt == 4) {plane, page} = addr_w[2][6:0];
        acnt = acnt == 4 ? 0 : acnt + 1;
      end
      else
      begin
        mem[col] = io_bus;
        col = col + 12'h001;
      end
    end
  always @(negedge pins.re_n)
    if (!pins.ce_n)
    begin
      dev_q = mem[col];
      col = col + 12'h001;
    end
endmodule : nbc_dev_model

// ### test/nbc_host_tb.sv
// nbc_host_tb: self-checking bench for the nand host
`timescale 1ns/1ps
module nbc_host_tb;
  // ----
  // bench
  // ----
  logic clk, sys_rst, req_valid, wp_allow, req_ready, rsp_valid, dev_ready, io_oe, dev_oe, rb_low;
  nbc_pkg::nbc_req_t req;
  nbc_pkg::nbc_pins_t pins;
  logic [15:0] rsp_data, io_out, io_in, dev_q, junk;
  logic [11:0] col_ptr, c;
  logic [16:0] r;
  logic [31:0] lfsr;
  logic [15:0] dv [3];
  logic [15:0] ea [5];
  logic [15:0] exp_q [$];
  int failures, comparisons;
  wire ready_busy_n = rb_low ? 1'b0 : 1'b1;
  assign io_in = io_oe ? io_out : (dev_oe ? dev_q : junk);
  nbc_host dut_u (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req), .wp_allow(wp_allow),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .dev_ready(dev_ready), .col_ptr(col_ptr),
    .pins(pins), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .ready_busy_n(ready_busy_n));
  nbc_dev_model dev_u (.pins(pins), .io_bus(io_in), .dev_q(dev_q), .dev_oe(dev_oe), .rb_low(rb_low));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) junk <= junk + 16'h3C5B;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // request, then wait until the host is idle again
  task automatic do_req(input nbc_pkg::nbc_op_t op, input logic wd, input logic [15:0] d, input logic [11:0] cc,
                        input logic [16:0] rr);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{op, wd, d, cc, rr};
    n = 0;
    while (req_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 200);
    if (n >= 200) failures++;
  endtask : do_req
  task automatic wait_rdy(input logic lvl);
    int n;
    n = 0;
    while (dev_ready !== lvl && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    check({15'h0000, dev_ready}, {15'h0000, lvl});
  endtask : wait_rdy
  always @(negedge clk)
    if (rsp_valid === 1'b1)
      check(rsp_data, exp_q.size() ? exp_q.pop_front() : 16'hDEAD);
  initial
  begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    wp_allow = 1'b1;
    junk = 16'h0000;
    lfsr = 32'h000149D7;
    failures = 0;
    comparisons = 0;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check({14'h0000, pins.ce_n, io_oe}, 16'h0002);
    for (int w = 0; w < 2; w++)
    begin
      lfsr = lfsr_next(lfsr);
      c = w ? 12'(lfsr % 1088) : 12'(lfsr % 2176);
      r = lfsr[28:12];
      ea = '{{8'h00, c[7:0]}, w ? {13'h0000, c[10:8]} : {12'h000, c[11:8]}, {8'h00, r[7:0]}, {8'h00, r[15:8]},
        {15'h0000, r[16]}};
      do_req(nbc_pkg::NBC_OP_CMD, w[0], 16'h0080, c, r);
      check({8'h00, dev_u.last_cmd}, 16'h0080);
      do_req(nbc_pkg::NBC_OP_ADDR, w[0], 16'h0000, c, r);
      for (int k = 0; k < 5; k++) check(dev_u.addr_w[k], ea[k]);
      check({9'h000, dev_u.plane, dev_u.page}, {9'h000, r[6], r[5:0]});
      for (int k = 0; k < 3; k++)
      begin
        lfsr = lfsr_next(lfsr);
        dv[k] = w ? lfsr[15:0] : {8'h00, lfsr[7:0]};
        do_req(nbc_pkg::NBC_OP_DIN, w[0], lfsr[15:0], c, r);
        check(w ? dev_u.mem[c + k] : {8'h00, dev_u.mem[c + k][7:0]}, dv[k]);
      end
      check({4'h0, col_ptr}, {4'h0, c + 12'h003});
      do_req(nbc_pkg::NBC_OP_CMD, w[0], 16'h0010, c, r);
      wait_rdy(1'b0);
      wait_rdy(1'b1);
      do_req(nbc_pkg::NBC_OP_ADDR, w[0], 16'h0000, c, r);
      for (int k = 0; k < 3; k++)
      begin
        exp_q.push_back(dv[k]);
        do_req(nbc_pkg::NBC_OP_DOUT, w[0], 16'h0000, c, r);
      end
      check({4'h0, col_ptr}, {4'h0, c + 12'h003});
    end
    wp_allow = 1'b0;
    @(negedge clk);
    req_valid = 1'b1;
    req.op = nbc_pkg::NBC_OP_DIN;
    repeat (3) @(negedge clk);
    check({15'h0000, req_ready}, 16'h0000);
    check({15'h0000, pins.wp_n}, 16'h0000);
    req_valid = 1'b0;
    do_req(nbc_pkg::NBC_OP_CMD, 1'b1, 16'h0010, c, r);
    repeat (10) @(negedge clk);
    check({15'h0000, dev_ready}, 16'h0001);
    check(16'(exp_q.size()), 16'h0000);
    wrap_up();
  end
  // over eighty times the expected run
  initial
  begin
    #500000;
    failures++;
    wrap_up();
  end
endmodule : nbc_host_tb
